/* core/dtm_defs.vh */
// Offsets, field positions, reset values and timing counts of the die temperature monitor
`ifndef DTM_DEFS_VH
`define DTM_DEFS_VH
`define DTM_ADDR_W         4
`define DTM_OFS_CFG        4'hd
`define DTM_OFS_THD        4'he
`define DTM_OFS_RES        4'hf
`define DTM_CFG_START_BIT  7
`define DTM_RES_EOC_BIT    7
`define DTM_FIELD_W        6
`define DTM_MODE_DEFAULT   2'h0
`define DTM_MODE_PROG      2'h1
`define DTM_THD_RESET      6'h00
`define DTM_RES_RESET      6'h00
`define DTM_DEF_THRESHOLD  6'h30
`define DTM_CONV_TIME_NS   40000
`define DTM_CLK_PERIOD_NS  40
`define DTM_CONV_CYCLES    ((`DTM_CONV_TIME_NS + `DTM_CLK_PERIOD_NS - 1) / `DTM_CLK_PERIOD_NS)
`define DTM_SAMPLE_CYCLES  64
`endif

/* core/dtm_regs.v */
// Die temperature monitor registers: threshold compare, warnings, manual conversion
// Function
// R1: The programmable threshold is used only when the mode field is 01.
// R2: The threshold register holds a six-bit read/write field in bits 5:0.
// R3: Temperature above the threshold sets both the warning irq flag and status flag.
// R4: In programmable mode the test is a plain greater-than with no hysteresis.
// R5: The result register holds the last conversion, 3 degrees per step, zero at -15.
// R6: Result bit 7 reads 1 while a conversion runs and 0 once the result is fresh.
// R7: Manual conversions run only when the mode field holds 10 or 11.
// R8: Mode 00 uses the built-in threshold; modes 1x disable warnings.
// R9: Writing 1 to the start bit begins a conversion; the bit clears when it ends.
`timescale 1ns/1ps
`include "dtm_defs.vh"
module dtm_regs #(
   parameter CONV_CYCLES   = `DTM_CONV_CYCLES,
   parameter SAMPLE_CYCLES = `DTM_SAMPLE_CYCLES,
   parameter DEF_THRESHOLD = `DTM_DEF_THRESHOLD
) (
   // Clock and reset
   input  wire       MCLK_IN,
   input  wire       RST_IN,
   // Register port from the serial interface
   input  wire [3:0] REG_ADDR_IN,
   input  wire [7:0] REG_WDATA_IN,
   input  wire       REG_WR_IN,
   input  wire       REG_RD_IN,
   output reg  [7:0] REG_RDATA_OUT,
   // Temperature sensor
   input  wire [5:0] TEMP_CODE_IN,
   // Warning flags to the status logic
   output reg        TEMP_WARN_IRQ_FLAG_OUT,
   output reg        TEMP_WARN_STATUS_FLAG_OUT,
   input  wire       TEMP_WARN_IRQ_CLR_IN,
   // Mode and start towards the rest of the monitor
   output wire [1:0] MONITOR_MODE_FIELD_OUT,
   output wire       CONV_START_OUT,
   output wire       CONV_BUSY_OUT
);
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   wire [5:0] temp_sync;
   reg  [1:0] monitor_mode_field_reg;
   reg        start_reg;
   reg  [5:0] warn_threshold_field_reg;
   reg  [5:0] temp_result_field_reg;
   reg        state_reg;
   reg [15:0] conv_cnt_reg;
   reg [15:0] samp_cnt_reg;
   reg  [5:0] auto_temp_reg;
   reg        warn_cond;
   reg  [7:0] rdata_next;
   reg        state_next;
   reg        start_next;
   reg [15:0] conv_cnt_next;
   reg  [5:0] result_next;
   reg [15:0] samp_cnt_next;
   reg  [5:0] auto_temp_next;

   function sel;
      input [3:0] a;
      input [3:0] o;
      sel = (a == o);
   endfunction

   // Plain compare, no hysteresis band in any mode
   function above;
      input [5:0] t;
      input [5:0] l;
      above = (t > l);
   endfunction

   wire wr_cfg = REG_WR_IN & sel(REG_ADDR_IN, `DTM_OFS_CFG);
   wire wr_thd = REG_WR_IN & sel(REG_ADDR_IN, `DTM_OFS_THD);
   wire start_req = wr_cfg & REG_WDATA_IN[`DTM_CFG_START_BIT] & REG_WDATA_IN[1]; // R7
   // Reload one short so busy lasts exactly CONV_CYCLES cycles
   wire [15:0] conv_load = CONV_CYCLES[15:0] - 16'h0001;

   // Multi-bit code: stage agreement filters bits that arrive skewed
   dtm_sync #(
      .W(6)
   ) u_sync (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .d_in  (TEMP_CODE_IN),
      .q_out (temp_sync)
   );

   assign MONITOR_MODE_FIELD_OUT = monitor_mode_field_reg;
   assign CONV_START_OUT         = start_reg;
   assign CONV_BUSY_OUT          = (state_reg == ST_CONV);

   // Config and threshold registers; the start bit lives in the sequencer
   always @(posedge MCLK_IN) begin
      if (RST_IN) begin
         monitor_mode_field_reg   <= `DTM_MODE_DEFAULT;
         warn_threshold_field_reg <= `DTM_THD_RESET;
      end else begin
         if (wr_cfg) begin
            monitor_mode_field_reg <= REG_WDATA_IN[1:0];
         end
         if (wr_thd) begin
            warn_threshold_field_reg <= REG_WDATA_IN[5:0]; // R2
         end
      end
   end

   // Manual conversion sequencer, next state
   always @* begin
      state_next    = state_reg;
      start_next    = start_reg;
      conv_cnt_next = conv_cnt_reg;
      result_next   = temp_result_field_reg;
      case (state_reg)
         ST_IDLE: begin
            // Writes while busy cannot restart a running conversion
            if (start_req) begin // R9
               state_next    = ST_CONV;
               start_next    = 1'b1;
               conv_cnt_next = conv_load;
            end
         end
         ST_CONV: begin
            if (conv_cnt_reg == 16'h0000) begin
               state_next  = ST_IDLE;
               start_next  = 1'b0; // R9
               result_next = temp_sync; // R5
            end else begin
               conv_cnt_next = conv_cnt_reg - 16'h0001;
            end
         end
         default: begin
            state_next = ST_IDLE;
            start_next = 1'b0;
         end
      endcase
   end

   always @(posedge MCLK_IN) begin
      if (RST_IN) begin
         state_reg             <= ST_IDLE;
         start_reg             <= 1'b0;
         conv_cnt_reg          <= 16'h0000;
         temp_result_field_reg <= `DTM_RES_RESET;
      end else begin
         state_reg             <= state_next;
         start_reg             <= start_next;
         conv_cnt_reg          <= conv_cnt_next;
         temp_result_field_reg <= result_next;
      end
   end

   // Periodic sample for the warning compare; the result register is left alone
   always @* begin
      samp_cnt_next  = samp_cnt_reg - 16'h0001;
      auto_temp_next = auto_temp_reg;
      if (samp_cnt_reg == 16'h0000) begin
         samp_cnt_next  = SAMPLE_CYCLES[15:0] - 16'h0001;
         auto_temp_next = temp_sync;
      end
   end

   always @(posedge MCLK_IN) begin
      if (RST_IN) begin
         samp_cnt_reg  <= 16'h0000;
         auto_temp_reg <= 6'h00;
      end else begin
         samp_cnt_reg  <= samp_cnt_next;
         auto_temp_reg <= auto_temp_next;
      end
   end

   always @* begin
      case (monitor_mode_field_reg)
         2'h0:    warn_cond = above(auto_temp_reg, DEF_THRESHOLD[5:0]); // R8
         2'h1:    warn_cond = above(auto_temp_reg, warn_threshold_field_reg); // R1 R4
         default: warn_cond = 1'b0; // R8
      endcase
   end

   // Irq flag sticky until cleared; a new event beats a clear in the same cycle
   always @(posedge MCLK_IN) begin
      if (RST_IN) begin
         TEMP_WARN_IRQ_FLAG_OUT <= 1'b0;
      end else begin
         if (warn_cond) begin
            TEMP_WARN_IRQ_FLAG_OUT <= 1'b1; // R3
         end else if (TEMP_WARN_IRQ_CLR_IN) begin
            TEMP_WARN_IRQ_FLAG_OUT <= 1'b0;
         end
      end
   end

   // Status follows the condition one cycle late
   always @(posedge MCLK_IN) begin
      if (RST_IN) begin
         TEMP_WARN_STATUS_FLAG_OUT <= 1'b0;
      end else begin
         TEMP_WARN_STATUS_FLAG_OUT <= warn_cond; // R3
      end
   end

   // Unmapped addresses read zero; writes to the result field are dropped
   always @* begin
      rdata_next = 8'h00;
      case (REG_ADDR_IN)
         `DTM_OFS_CFG: rdata_next = {start_reg, 5'h00, monitor_mode_field_reg};
         `DTM_OFS_THD: rdata_next = {2'h0, warn_threshold_field_reg};
         `DTM_OFS_RES: rdata_next = {CONV_BUSY_OUT, 1'b0, temp_result_field_reg}; // R6
         default:      rdata_next = 8'h00;
      endcase
   end

   always @(posedge MCLK_IN) begin
      if (RST_IN) begin
         REG_RDATA_OUT <= 8'h00;
      end else if (REG_RD_IN) begin
         REG_RDATA_OUT <= rdata_next;
      end
   end
endmodule // dtm_regs

/* core/dtm_sync.v */
// Three-stage synchroniser with agreement filter for an external level
`timescale 1ns/1ps
module dtm_sync #(
   parameter W = 6
) (
   // Clock and reset
   input  wire         clk_in,
   input  wire         rst_in,
   // Data
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] q_out
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;

   always @(posedge clk_in) begin
      if (rst_in) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         q_out  <= {W{1'b0}};
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q_out <= s3_reg;
         end
      end
   end
endmodule // dtm_sync

/* test/dtm_host_model.sv */
// Host model on the register port, driving at falling edges
`timescale 1ns/1ps
module dtm_host_model (
   input  logic       clk_in,
   output logic [3:0] addr_out,
   output logic [7:0] wdata_out,
   output logic       wr_out,
   output logic       rd_out,
   input  logic [7:0] rdata_in
);
   initial {addr_out, wdata_out, wr_out, rd_out} = 14'h0;
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge clk_in);
      {addr_out, wdata_out, wr_out, rd_out} = {a, d, w, !w};
      @(negedge clk_in);
      q = rdata_in;
      // Released address and data lines show inverted values, never the stale ones; wr and rd go low
      {addr_out, wdata_out, wr_out, rd_out} = {~a, ~d, 2'h0};
   endtask
endmodule // dtm_host_model

/* test/dtm_regs_monitor.sv */
// Checker on the register block ports
`timescale 1ns/1ps
module dtm_regs_monitor (
   // Watched ports
   input logic       MCLK_IN,
   input logic       RST_IN,
   input logic [3:0] REG_ADDR_IN,
   input logic [7:0] REG_WDATA_IN,
   input logic       REG_WR_IN,
   input logic       REG_RD_IN,
   input logic [7:0] REG_RDATA_OUT,
   input logic       TEMP_WARN_IRQ_FLAG_OUT,
   input logic       TEMP_WARN_STATUS_FLAG_OUT,
   input logic       TEMP_WARN_IRQ_CLR_IN,
   input logic [1:0] MONITOR_MODE_FIELD_OUT,
   input logic       CONV_START_OUT,
   input logic       CONV_BUSY_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   // Start while busy is ignored, so only idle writes count
   wire wcfg = REG_WR_IN && REG_ADDR_IN == 4'hd && !CONV_BUSY_OUT && REG_WDATA_IN[7];
   chk_start_refused: assert property (wcfg && !REG_WDATA_IN[1] |=> !CONV_BUSY_OUT)
      else $error("start taken in a warning mode");
   chk_start_taken: assert property (wcfg && REG_WDATA_IN[1] |=> CONV_START_OUT)
      else $error("start not taken");
   chk_conv_ends: assert property ($rose(CONV_BUSY_OUT) |-> CONV_BUSY_OUT[*3] ##[1:3] !CONV_BUSY_OUT)
      else $error("conversion length wrong");
   chk_eoc_read: assert property (REG_RD_IN && REG_ADDR_IN == 4'hf |=> REG_RDATA_OUT[7] == $past(CONV_BUSY_OUT))
      else $error("end flag read wrong");
   chk_thd_upper: assert property (REG_RD_IN && REG_ADDR_IN == 4'he |=> REG_RDATA_OUT[7:6] == 2'h0)
      else $error("threshold upper bits set");
   chk_warn_off: assert property ((MONITOR_MODE_FIELD_OUT[1])[*6] |-> !TEMP_WARN_STATUS_FLAG_OUT)
      else $error("warning in manual mode");
   chk_irq_with_status: assert property ($rose(TEMP_WARN_STATUS_FLAG_OUT) |-> ##[0:1] TEMP_WARN_IRQ_FLAG_OUT)
      else $error("irq flag missing");
   chk_irq_sticky: assert property (TEMP_WARN_IRQ_FLAG_OUT && !TEMP_WARN_IRQ_CLR_IN |=> TEMP_WARN_IRQ_FLAG_OUT)
      else $error("irq flag dropped");
endmodule // dtm_regs_monitor
bind dtm_regs dtm_regs_monitor chk_u (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT), .TEMP_WARN_IRQ_FLAG_OUT(TEMP_WARN_IRQ_FLAG_OUT),
   .TEMP_WARN_STATUS_FLAG_OUT(TEMP_WARN_STATUS_FLAG_OUT), .TEMP_WARN_IRQ_CLR_IN(TEMP_WARN_IRQ_CLR_IN),
   .MONITOR_MODE_FIELD_OUT(MONITOR_MODE_FIELD_OUT), .CONV_START_OUT(CONV_START_OUT),
   .CONV_BUSY_OUT(CONV_BUSY_OUT));

/* test/dtm_regs_tb_top.sv */
// Self-checking bench for the temperature monitor registers
`timescale 1ns/1ps
module dtm_regs_tb_top;
   logic       clk, rst, wr, rd, clr, irq, sts, start, busy;
   logic [3:0] addr;
   logic [7:0] wd, rdat, q;
   logic [5:0] temp;
   logic [1:0] mode;
   int         miscompares = 0, n_checks = 0, cyc = 0;
   dtm_host_model host_u (.clk_in(clk), .addr_out(addr), .wdata_out(wd), .wr_out(wr),
      .rd_out(rd), .rdata_in(rdat));
   dtm_regs #(.CONV_CYCLES(4), .SAMPLE_CYCLES(2)) dut_u (.MCLK_IN(clk), .RST_IN(rst),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdat), .TEMP_CODE_IN(temp), .TEMP_WARN_IRQ_FLAG_OUT(irq),
      .TEMP_WARN_STATUS_FLAG_OUT(sts), .TEMP_WARN_IRQ_CLR_IN(clr),
      .MONITOR_MODE_FIELD_OUT(mode), .CONV_START_OUT(start), .CONV_BUSY_OUT(busy));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      host_u.xfer(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      host_u.xfer(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   // Lets the sensor code pass the synchroniser and a sample period
   task automatic settle;
      repeat (12) @(negedge clk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      rst = 1; clr = 0; temp = 6'h21;
      repeat (6) @(negedge clk);
      rst = 0;
      rd_chk(4'he, 8'h00);
      rd_chk(4'hf, 8'h00);
      wr_reg(4'he, 8'hff);
      rd_chk(4'he, 8'h3f);
      wr_reg(4'he, 8'h20);
      wr_reg(4'hd, 8'h01);
      chk({6'h0, mode}, 8'h01);
      settle();
      chk({6'h0, irq, sts}, 8'h03);
      temp = 6'h20;
      settle();
      chk({6'h0, irq, sts}, 8'h02);
      clr = 1;
      @(negedge clk) clr = 0;
      wr_reg(4'hd, 8'h00);
      settle();
      chk({6'h0, irq, sts}, 8'h00);
      temp = 6'h31;
      settle();
      chk({6'h0, irq, sts}, 8'h03);
      $display("warning tests done");
      wr_reg(4'hd, 8'h02);
      settle();
      chk({6'h0, irq, sts}, 8'h02);
      wr_reg(4'hd, 8'h80);
      chk({7'h0, busy}, 8'h00);
      for (int m = 2; m < 4; m++) begin
         temp = (m == 2) ? 6'h3f : 6'h05;
         settle();
         wr_reg(4'hd, {6'h20, m[1:0]});
         chk({7'h0, busy}, 8'h01);
         chk({7'h0, start}, 8'h01);
         rd_chk(4'hf, {2'h2, ((m == 2) ? 6'h00 : 6'h3f)});
         for (int i = 0; i < 20 && busy; i++) @(negedge clk);
         chk({7'h0, start}, 8'h00);
         rd_chk(4'hf, {2'h0, temp});
         rd_chk(4'hd, {6'h0, m[1:0]});
      end
      $display("conversion tests done");
      summarize();
   end
endmodule // dtm_regs_tb_top
